// ===== hw/byte_move_pkg.sv
// constants, register map and types of the byte move execution unit
// assumes a single clock domain and an Avalon-MM master for software access
// Function
// RQ1: eight general registers, each seen as high/low bytes and low/extended words; the unit moves only the high/low byte views
// RQ2: any full 32-bit general register serves as memory address register
// RQ3: condition flags register holds negative, zero, overflow and carry flags
// RQ4: byte moves set N and Z from value, clear V, keep C, H, I
// RQ5: post-increment load reads byte at address, then adds one; 2 bytes, 6 states
// RQ6: 16-bit displacement load adds sign-extended offset; 4 bytes, 6 states
// RQ7: 24-bit displacement load adds offset; 8 bytes, 10 states
// RQ8: negative flag is byte bit 7; zero flag only when all eight bits zero
package byte_move_pkg;

    // ==========================================================
    // register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DISP   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FLAGS  = 8'h0C;
    localparam logic [7:0] OFS_GPR0   = 8'h10;
    localparam logic [7:0] OFS_GPR7   = 8'h2C;

    // ==========================================================
    // field positions
    localparam int CTRL_OP_LSB   = 0;
    localparam int CTRL_DST_LSB  = 4;
    localparam int CTRL_SRC_LSB  = 8;
    localparam int STAT_CNT_LSB  = 4;
    localparam int STAT_LEN_LSB  = 8;
    localparam int FLAG_I        = 7;
    localparam int FLAG_H        = 5;
    localparam int FLAG_N        = 3;
    localparam int FLAG_Z        = 2;
    localparam int FLAG_V        = 1;
    localparam int FLAG_C        = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0]  FLAGS_RESET = 8'h80;
    localparam logic [31:0] GPR_RESET   = 32'h0000_0000;
    localparam logic [23:0] DISP_RESET  = 24'h00_0000;

    // ==========================================================
    // operations, state counts and lengths in bytes
    typedef enum logic [2:0] {
        OP_IMM     = 3'h0,
        OP_REG     = 3'h1,
        OP_IND     = 3'h2,
        OP_DISP16  = 3'h3,
        OP_DISP24  = 3'h4,
        OP_POSTINC = 3'h5
    } move_op_t;

    localparam logic [3:0] STATES_IMM     = 4'h2;
    localparam logic [3:0] STATES_REG     = 4'h2;
    localparam logic [3:0] STATES_IND     = 4'h4;
    localparam logic [3:0] STATES_DISP16  = 4'h6;
    localparam logic [3:0] STATES_DISP24  = 4'hA;
    localparam logic [3:0] STATES_POSTINC = 4'h6;
    localparam logic [3:0] LEN_SHORT      = 4'h2;
    localparam logic [3:0] LEN_DISP16     = 4'h4;
    localparam logic [3:0] LEN_DISP24     = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } exec_state_t;

endpackage

// ===== hw/move_flag_update.sv
// flag update of one byte move
// assumes the caller registers the result
`timescale 1ns/1ps
module move_flag_update
    import byte_move_pkg::*;
(
    input  wire logic [7:0] value,
    input  wire logic [7:0] flagsIn,
    output logic      [7:0] flagsOut
);
    always_comb begin
        flagsOut         = flagsIn;             // RQ4
        flagsOut[FLAG_N] = value[7];            // RQ8
        flagsOut[FLAG_Z] = (value == 8'h00);    // RQ8
        flagsOut[FLAG_V] = 1'b0;                // RQ4
    end
endmodule

// ===== hw/byte_move_unit.sv
// byte move execution unit with register file and condition flags
// assumes an Avalon-MM master on the same clock and a byte memory that answers on memRdValid
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module byte_move_unit
    import byte_move_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic      [23:0] memAddr,
    output logic             memRead,
    input  wire logic [7:0]  memRdData,
    input  wire logic        memRdValid,
    output logic             busy
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0][31:0] gpr;
        logic [7:0]       flags;
        logic [23:0]      disp;
        move_op_t         op;
        logic [3:0]       dst;
        logic [3:0]       src;
        exec_state_t      st;
        logic [3:0]       cnt;
        logic [3:0]       states;
        logic [3:0]       len;
        logic [7:0]       data;
        logic             haveData;
        logic [31:0]      rdata;
        logic             waitReq;
        logic [23:0]      memAddr;
        logic             memRead;
        logic             busy;
    } unit_state_t;

    unit_state_t s;
    unit_state_t next_s;
    logic [7:0]  moveByte;
    logic [7:0]  newFlags;

    // ==========================================================
    // helpers
    function automatic logic [31:0] mergeBe(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // index bit 3 picks the low byte, otherwise the high byte of the low word
    function automatic logic [7:0] getByte(input logic [7:0][31:0] g, input logic [3:0] idx);
        return idx[3] ? g[idx[2:0]][7:0] : g[idx[2:0]][15:8];
    endfunction

    function automatic logic [3:0] statesOf(input move_op_t op);
        unique case (op)
            OP_IMM:     return STATES_IMM;
            OP_REG:     return STATES_REG;
            OP_IND:     return STATES_IND;
            OP_DISP16:  return STATES_DISP16;
            OP_DISP24:  return STATES_DISP24;
            OP_POSTINC: return STATES_POSTINC;
            default:    return 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] lenOf(input move_op_t op);
        unique case (op)
            OP_DISP16: return LEN_DISP16;    // RQ6
            OP_DISP24: return LEN_DISP24;    // RQ7
            default:   return LEN_SHORT;     // RQ5
        endcase
    endfunction

    function automatic logic isLoad(input move_op_t op);
        return (op == OP_IND) || (op == OP_DISP16) || (op == OP_DISP24) || (op == OP_POSTINC);
    endfunction

    // ==========================================================
    // flag unit
    assign moveByte = (s.op == OP_IMM) ? s.disp[7:0]
                    : (s.op == OP_REG) ? getByte(s.gpr, s.src)
                    : s.data;

    move_flag_update flagUnit (
        .value    (moveByte),
        .flagsIn  (s.flags),
        .flagsOut (newFlags)
    );

    // ==========================================================
    // next state
    always_comb begin
        logic        req;
        logic        done;
        logic [31:0] ea;
        logic [31:0] dword;
        move_op_t    wop;
        req     = read || write;
        done    = 1'b0;
        ea      = 32'h0000_0000;
        dword   = 32'h0000_0000;
        wop     = move_op_t'(writedata[CTRL_OP_LSB +: 3]);
        next_s  = s;
        next_s.memRead = 1'b0;

        // the answer comes one cycle after the request is seen, then waitrequest rises again
        next_s.waitReq = !(req && s.waitReq);
        if (read && s.waitReq) begin
            unique case (address)
                OFS_CTRL:   next_s.rdata = {20'h0_0000, s.src, s.dst, 1'b0, s.op};
                OFS_DISP:   next_s.rdata = {8'h00, s.disp};
                OFS_STATUS: next_s.rdata = {20'h0_0000, s.len, s.states, 3'b000,
                                            s.st == ST_EXEC};
                OFS_FLAGS:  next_s.rdata = {24'h00_0000, s.flags};    // RQ3
                default: begin
                    if (address >= OFS_GPR0 && address <= OFS_GPR7 && address[1:0] == 2'b00) begin
                        next_s.rdata = s.gpr[3'(address[4:2] - 3'h4)];    // RQ1
                    end else begin
                        next_s.rdata = 32'h0000_0000;
                    end
                end
            endcase
        end

        // writes land at the edge where waitrequest is seen low; ignored while busy
        // so software cannot race the instruction that owns the registers
        if (write && !s.waitReq && s.st == ST_IDLE) begin
            unique case (address)
                OFS_CTRL: begin
                    if (byteenable[0] && statesOf(wop) != 4'h0) begin
                        next_s.op       = wop;
                        next_s.dst      = writedata[CTRL_DST_LSB +: 4];
                        next_s.src      = writedata[CTRL_SRC_LSB +: 4];
                        next_s.states   = statesOf(wop);
                        next_s.len      = lenOf(wop);
                        next_s.st       = ST_EXEC;
                        next_s.busy     = 1'b1;
                        next_s.cnt      = 4'h1;
                        next_s.haveData = 1'b0;
                        unique case (wop)
                            OP_DISP16: ea = s.gpr[next_s.src[2:0]]
                                          + {{16{s.disp[15]}}, s.disp[15:0]};    // RQ6
                            OP_DISP24: ea = s.gpr[next_s.src[2:0]]
                                          + {{8{s.disp[23]}}, s.disp};           // RQ7
                            default:   ea = s.gpr[next_s.src[2:0]];              // RQ2
                        endcase
                        next_s.memAddr = ea[23:0];
                        next_s.memRead = isLoad(wop);
                    end
                end
                OFS_DISP: begin
                    dword       = mergeBe({8'h00, s.disp}, writedata, byteenable);
                    next_s.disp = dword[23:0];
                end
                OFS_FLAGS: begin
                    if (byteenable[0]) begin
                        next_s.flags = writedata[7:0];
                    end
                end
                OFS_STATUS: begin
                end
                default: begin
                    if (address >= OFS_GPR0 && address <= OFS_GPR7 && address[1:0] == 2'b00) begin
                        next_s.gpr[3'(address[4:2] - 3'h4)] =
                            mergeBe(s.gpr[3'(address[4:2] - 3'h4)], writedata, byteenable);
                    end
                end
            endcase
        end

        // ======================================================
        // execution: one clock per state; a slow memory stretches the last state
        unique case (s.st)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                if (memRdValid && !s.haveData) begin
                    next_s.data     = memRdData;
                    next_s.haveData = 1'b1;
                end
                done = (s.cnt >= s.states) && (!isLoad(s.op) || s.haveData);
                if (s.cnt < s.states) begin
                    next_s.cnt = s.cnt + 4'h1;
                end
                if (done) begin
                    next_s.st = ST_IDLE;
                    next_s.busy = 1'b0;
                    if (s.op == OP_POSTINC) begin
                        next_s.gpr[s.src[2:0]] = s.gpr[s.src[2:0]] + 32'h0000_0001;    // RQ5
                    end
                    // increment first, so a byte loaded into the same register survives
                    if (s.dst[3]) begin
                        next_s.gpr[s.dst[2:0]][7:0] = moveByte;     // RQ1
                    end else begin
                        next_s.gpr[s.dst[2:0]][15:8] = moveByte;    // RQ1
                    end
                    next_s.flags = newFlags;    // RQ4
                end
            end
            default: begin
                next_s.st = ST_IDLE;
                next_s.busy = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.gpr      <= {8{GPR_RESET}};
            s.flags    <= FLAGS_RESET;
            s.disp     <= DISP_RESET;
            s.waitReq  <= 1'b1;
            s.st       <= ST_IDLE;
            s.op       <= OP_IMM;
        end else begin
            s <= next_s;
        end
    end

    assign readdata    = s.rdata;
    assign waitrequest = s.waitReq;
    assign memAddr     = s.memAddr;
    assign memRead     = s.memRead;
    // own flop rather than a state decode, so the pin never glitches
    assign busy        = s.busy;

endmodule

// ===== testbench/byte_move_props.sv
// assertions on the ports of the byte move unit
// assumes a bind from the testbench top and one clock domain
`timescale 1ns/1ps
module byte_move_props
    import byte_move_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [23:0] memAddr,
    input wire logic        memRead,
    input wire logic        memRdValid,
    input wire logic        busy
);
    // ==========================================================
    // helper: accepted move start, its op and the busy length
    logic       start;
    logic [2:0] op;
    logic [3:0] cnt;
    logic [3:0] need;
    assign start = write && !waitrequest && address == OFS_CTRL && !busy
                   && byteenable[0] && writedata[2:0] < 3'h6;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op  <= 3'h0;
            cnt <= 4'h0;
        end else begin
            if (start) op <= writedata[2:0];
            cnt <= busy ? cnt + 4'h1 : 4'h0;
        end
    end
    always_comb begin
        case (op)
            3'h2: need = STATES_IND;
            3'h3: need = STATES_DISP16;
            3'h4: need = STATES_DISP24;
            3'h5: need = STATES_POSTINC;
            default: need = STATES_IMM;
        endcase
    end
    // ==========================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_load;
        start && writedata[2:0] > 3'h1;
    endsequence
    sequence s_run10;
        busy [*8] ##1 busy [*2];
    endsequence
    a_req_ack: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request not answered in one cycle");
    a_ack_one: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_no_req: assert property (!read && !write |=> waitrequest)
        else $error("answer without a request");
    a_busy_start: assert property (start |=> busy)
        else $error("move did not start");
    a_mem_pulse: assert property (s_load |=> memRead ##1 !memRead)
        else $error("load read strobe wrong");
    a_addr_hold: assert property (busy ##1 busy |-> $stable(memAddr))
        else $error("load address moved while busy");
    a_disp24_run: assert property (start && writedata[2:0] == 3'h4 |=> s_run10)
        else $error("long displacement load too short");
    a_state_count: assert property ($fell(busy) && !$past(memRdValid) |-> cnt == need)
        else $error("wrong state count");
    a_unmapped_zero: assert property (read && !waitrequest && address > OFS_GPR7
                                      |-> readdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

// ===== testbench/testbench.sv
// self-checking bench of the byte move unit over its register bus
// assumes the package, design and checker are compiled before it
`timescale 1ns/1ps
module testbench import byte_move_pkg::*;;
    logic        clk, rst, read, write, waitrequest, memRead, memRdValid, busy;
    logic [7:0]  address, memRdData, fl;
    logic [3:0]  byteenable;
    logic [23:0] memAddr;
    logic [31:0] writedata, readdata, d;
    int          miscompares, nCompared;

    byte_move_unit byte_move_unit_i (.clk, .rst, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .memAddr, .memRead, .memRdData,
        .memRdValid, .busy);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==========================================================
    // memory: answers one cycle after the strobe, scrambles when idle
    function automatic logic [7:0] mb(input logic [23:0] a);
        return a[7:0] ^ a[23:16] ^ 8'hC3;
    endfunction
    always @(posedge clk) begin
        if (rst) begin
            memRdValid <= 1'b0;
            memRdData  <= 8'h00;
        end else begin
            memRdValid <= memRead;
            memRdData  <= memRead ? mb(memAddr) : ~memRdData;
        end
    end
    // ==========================================================
    // bus and check tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        address   <= a;
        writedata <= v;
        write     <= w;
        read      <= !w;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(1'b1, a, v);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic ln(input logic [3:0] l);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("length", {28'h0, l}, {28'h0, d[11:8]});
    endtask
    function automatic logic [31:0] ctl(input int op, input int dst, input int src);
        return {20'h0, src[3:0], dst[3:0], 1'b0, op[2:0]};
    endfunction
    // counts busy cycles; zero when the start was refused
    task automatic run(input logic [31:0] c, input int s);
        int n;
        n = 0;
        wr(OFS_CTRL, c);
        while (busy === 1'b1) begin
            n++;
            @(posedge clk);
        end
        chk("states", s, n);
    endtask
    task automatic mv(input logic [31:0] c, input int s, input logic [7:0] b);
        run(c, s);
        fl = {fl[7:4], b[7], b == 8'h00, 1'b0, fl[0]};
        rc(OFS_FLAGS, {24'h0, fl});
    endtask
    task automatic results();
        $display("compared %0d mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ==========================================================
    // tests
    initial begin
        rst = 1'b1; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 32'h0;
        byteenable = 4'hF;
        miscompares = 0; nCompared = 0; fl = 8'h80;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rc(OFS_FLAGS, 32'h80);
        rc(OFS_GPR7, 32'h0);
        rc(8'h40, 32'h0);
        $display("test reset done");
        wr(OFS_FLAGS, 32'hA3);
        fl = 8'hA3;
        wr(8'h1C, 32'h11223344);
        wr(OFS_DISP, 32'h80);
        mv(ctl(0, 11, 0), 2, 8'h80);
        rc(8'h1C, 32'h11223380);
        wr(OFS_DISP, 32'h0);
        mv(ctl(0, 3, 0), 2, 8'h00);
        rc(8'h1C, 32'h11220080);
        mv(ctl(1, 5, 11), 2, 8'h80);
        rc(8'h24, 32'h8000);
        $display("test byte views done");
        wr(OFS_GPR0, 32'h5555AAAA);
        byteenable <= 4'h3;
        wr(8'h14, 32'hFFFF00C3);
        byteenable <= 4'hF;
        rc(8'h14, 32'hC3);
        mv(ctl(2, 8, 1), 4, 8'h00);
        rc(OFS_GPR0, 32'h5555AA00);
        wr(8'h14, 32'h1000);
        wr(OFS_DISP, 32'hFFF0);
        mv(ctl(3, 8, 1), 6, 8'h33);
        rc(OFS_GPR0, 32'h5555AA33);
        ln(4'h4);
        wr(8'h18, 32'h100);
        wr(OFS_DISP, 32'h800010);
        mv(ctl(4, 0, 2), 10, 8'h53);
        rc(OFS_GPR0, 32'h55555333);
        ln(4'h8);
        $display("test displacement done");
        wr(OFS_GPR7, 32'hFFFF);
        mv(ctl(5, 15, 7), 6, 8'h3C);
        rc(OFS_GPR7, 32'h1003C);
        ln(4'h2);
        run(ctl(6, 8, 1), 0);
        rc(OFS_GPR0, 32'h55555333);
        $display("test post increment done");
        results();
    end
    initial begin
        #200000;
        miscompares++;
        results();
    end
endmodule

bind byte_move_unit byte_move_props byte_move_props_i (.clk, .rst, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .memAddr, .memRead,
    .memRdValid, .busy);
